// [core/fswd_cfg.svh]
// Timing counts, field positions and reset values for the fail-safe watchdog control.
// Included by the design modules; definitions only.
`ifndef FSWD_CFG_SVH
`define FSWD_CFG_SVH
`define FSWD_CLK_HZ         50_000_000
`define FSWD_WD_MS_00       620
`define FSWD_WD_MS_01       310
`define FSWD_WD_MS_10       2500
`define FSWD_WD_MS_11       1250
`define FSWD_HBLANK_NS      10_000
`define FSWD_CMD_BITS       8
`define FSWD_CFG_RESET      8'h00
`define FSWD_FAULT_RESET    8'h00
`define FSWD_CMD_WD_ADDR    4'h1
`define FSWD_CMD_IN_ADDR    4'h2
`define FSWD_CMD_OC_ADDR    4'h3
`define FSWD_FS_OFF         2'h0
`define FSWD_FS_ON          2'h1
`define FSWD_FS_DISABLED    2'h2
`endif

// [core/fswd_pkg.sv]
// Types shared by the fail-safe watchdog control modules.
// Assumes fswd_cfg.svh is on the include path.
package fswd_pkg;
   typedef enum logic [1:0] {FSWD_SLEEP, FSWD_NORMAL, FSWD_FAILSAFE} fswd_mode_t;
   typedef enum logic [1:0] {FSWD_IN_DIRECT, FSWD_IN_OFF, FSWD_IN_AND, FSWD_IN_OR} fswd_in_t;
endpackage

// [core/fswd_serial_if.sv]
// Interface carrying serial transfer events from the shifter to the control core.
// Assumes a single clock; all signals are synchronous to core_clk.
`timescale 1ns/1ps
interface fswd_serial_if;
   logic       cmd_valid;
   logic [7:0] cmd_data;
   logic [7:0] status_word;
   modport shifter (output cmd_valid, output cmd_data, input status_word);
   modport core    (input cmd_valid, input cmd_data, output status_word);
endinterface

// [core/fswd_serial.sv]
// Serial slave shifter: takes 8-bit commands MSB first, returns the status word.
// Assumes synchronised chip select and serial clock, sampled on core_clk.
`timescale 1ns/1ps
`include "fswd_cfg.svh"
module fswd_serial
   import fswd_pkg::*;
(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Synchronised serial pins
   input  wire logic       cs_n_s,
   input  wire logic       sclk_s,
   input  wire logic       sdi_s,
   output logic            sdo_o,
   output logic            sdo_oe,
   // Core side
   fswd_serial_if.shifter  sif
);
   logic [7:0] sh_q, sh_d, tx_q, tx_d;
   logic [2:0] cnt_q, cnt_d;
   logic       sclk_q, cs_q, sdo_q, sdo_d, val_d, val_q;

   // Next-state of the shifter
   always_comb begin
      sh_d  = sh_q;
      tx_d  = tx_q;
      cnt_d = cnt_q;
      sdo_d = sdo_q;
      val_d = 1'b0;
      if (cs_q && !cs_n_s) begin
         tx_d  = sif.status_word;       // Load status on select
         sdo_d = sif.status_word[7];
         cnt_d = 3'h0;
      end else if (!cs_n_s && sclk_s && !sclk_q) begin
         sh_d  = {sh_q[6:0], sdi_s};
         tx_d  = {tx_q[6:0], 1'b0};
         sdo_d = tx_q[6];                // Changes after rising edge
         cnt_d = 3'(cnt_q + 3'h1);
         val_d = (cnt_q == 3'h7);
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sh_q <= 8'h00; tx_q <= 8'h00; cnt_q <= 3'h0;
         sclk_q <= 1'b0; cs_q <= 1'b1; sdo_q <= 1'b0; val_q <= 1'b0;
      end else begin
         sh_q <= sh_d; tx_q <= tx_d; cnt_q <= cnt_d;
         sclk_q <= sclk_s; cs_q <= cs_n_s; sdo_q <= sdo_d; val_q <= val_d;
      end
   end

   assign sif.cmd_valid = val_q;
   assign sif.cmd_data  = sh_q;
   assign sdo_o  = sdo_q;
   assign sdo_oe = !cs_n_s && !cs_q;   // Driven only while selected

   // Output enable follows chip select
   a_sdo_oe_select: assert property (@(posedge core_clk) disable iff (!reset_n)
      cs_n_s |-> !sdo_oe) else $error("sdo driven while deselected");
   a_sdo_shift_edge: assert property (@(posedge core_clk) disable iff (!reset_n)
      (!cs_n_s && !cs_q && !(sclk_s && !sclk_q)) |=> $stable(sdo_o))
      else $error("sdo changed without sclk rise");
endmodule

// [core/fswd_top.sv]
// Fail-safe watchdog control of a high-side load switch: modes, watchdog, drive and fault flag.
// Assumes all pins are asynchronous to core_clk; the failsafe resistor is pre-decoded to two bits.
// Operation
// - Watchdog runs only while wake input is high.
// - Reset low clears configuration and fault registers.
// - Reset low with wake low enters sleep with load output off.
// - Reset low-to-high transition starts the watchdog timer.
// - Direct input drives load; its action set by serial command.
// - Fault flag open-drain, pulled low while any fault is present.
// - Fault bits are shifted out on serial data output.
// - After timeout, output on or off per failsafe select.
// - Failsafe select grounded disables watchdog and fail-safe.
// - Serial output driven only while chip select is low.
// - Serial output changes after serial clock rising edge.
// - High blanking window tolerates current up to high trip top.
// - Low blanking window applies programmable low trip threshold.
// - Wake and reset both low means sleep, settings zero.
// - Watchdog expiry from missing traffic enters fail-safe mode.
// - Period field: 00=620, 01=310, 10=2500, 11=1250 ms.
`timescale 1ns/1ps
`include "fswd_cfg.svh"
module fswd_top
   import fswd_pkg::*;
#(
   parameter int unsigned CLK_HZ  = `FSWD_CLK_HZ,
   parameter int unsigned MS_DIV  = `FSWD_CLK_HZ / 1000
)(
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset_n,
   // Control pins
   input  wire logic       wake_in,
   input  wire logic       dev_reset_n,
   input  wire logic       direct_in,
   input  wire logic [1:0] failsafe_select_input,
   // Serial pins
   input  wire logic       chip_select_n,
   input  wire logic       serial_clk,
   input  wire logic       serial_din,
   output logic            serial_dout,
   output logic            serial_dout_oe,
   // Power stage sense
   input  wire logic       oc_high_trip,
   input  wire logic       oc_low_trip,
   input  wire logic       thermal_fault,
   // Outputs
   output logic            load_switch_output,
   output logic            fault_flag_n_o,
   output logic            fault_flag_n_oe,
   output logic [1:0]      low_trip_level_sel
);
   localparam int unsigned HBLANK_CYC = (`FSWD_HBLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

   // Two-flop synchronisers for every pin except thermal_fault
   logic [9:0] s1_q, s2_q;
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         // Chip select resets to its idle high level, so no false select follows reset
         s1_q <= 10'h010;
         s2_q <= 10'h010;
      end else begin
         s1_q <= {wake_in, dev_reset_n, direct_in, failsafe_select_input, chip_select_n,
                  serial_clk, serial_din, oc_high_trip, oc_low_trip};
         s2_q <= s1_q;
      end
   end
   logic wake_s, rst_s, din_s, cs_s, sclk_s, sdi_s, och_s, ocl_s;
   logic [1:0] fsi_s;
   assign {wake_s, rst_s, din_s, fsi_s, cs_s, sclk_s, sdi_s, och_s, ocl_s} = s2_q;

   fswd_serial_if sif ();
   fswd_serial u_serial (
      .core_clk (core_clk), .reset_n (reset_n), .cs_n_s (cs_s), .sclk_s (sclk_s),
      .sdi_s (sdi_s), .sdo_o (serial_dout), .sdo_oe (serial_dout_oe), .sif (sif));

   // Watchdog period decode, used for the expiry compare
   function automatic logic [11:0] wd_ms(input logic [1:0] sel);
      case (sel)
         2'h0:    wd_ms = 12'(`FSWD_WD_MS_00);
         2'h1:    wd_ms = 12'(`FSWD_WD_MS_01);
         2'h2:    wd_ms = 12'(`FSWD_WD_MS_10);
         default: wd_ms = 12'(`FSWD_WD_MS_11);
      endcase
   endfunction

   fswd_mode_t mode_q, mode_d;
   fswd_in_t   in_mode_q, in_mode_d;
   logic [1:0] watchdog_period_sel_q, watchdog_period_sel_d, lo_thr_q, lo_thr_d;
   logic       sw_on_q, sw_on_d, rst_prev_q, wd_run_q, wd_run_d;
   logic [11:0] ms_q, ms_d;
   logic [31:0] div_q, div_d;
   logic [15:0] hb_q, hb_d;
   logic [7:0]  fault_q, fault_d;
   logic        ms_tick, expire, fs_disabled, any_fault, drive, kick;

   assign ms_tick     = (div_q == 32'(MS_DIV - 1));
   assign fs_disabled = (fsi_s == `FSWD_FS_DISABLED);
   assign kick        = sif.cmd_valid;
   assign expire      = wd_run_q && ms_tick && (ms_q >= wd_ms(watchdog_period_sel_q) - 12'h001);
   assign any_fault   = |fault_q;

   // Next state of mode, config, watchdog and faults
   always_comb begin
      mode_d = mode_q; in_mode_d = in_mode_q; watchdog_period_sel_d = watchdog_period_sel_q;
      lo_thr_d = lo_thr_q; sw_on_d = sw_on_q; wd_run_d = wd_run_q;
      ms_d = ms_q; div_d = ms_tick ? 32'h0000_0000 : div_q + 32'h0000_0001;
      hb_d = hb_q; fault_d = fault_q;
      if (!rst_s) begin                           // Reset pin low clears settings
         in_mode_d = FSWD_IN_DIRECT; watchdog_period_sel_d = 2'h0; lo_thr_d = 2'h0;
         sw_on_d = 1'b0; fault_d = `FSWD_FAULT_RESET; wd_run_d = 1'b0; ms_d = 12'h000;
         if (!wake_s) mode_d = FSWD_SLEEP;
      end else begin
         if (mode_q == FSWD_SLEEP) mode_d = FSWD_NORMAL;
         if (!rst_prev_q) begin                   // Rising reset starts timer
            wd_run_d = 1'b1; ms_d = 12'h000;
         end
         if (kick) begin
            ms_d = 12'h000;
            case (sif.cmd_data[7:4])              // Command decode
               `FSWD_CMD_WD_ADDR: watchdog_period_sel_d = sif.cmd_data[1:0];
               `FSWD_CMD_IN_ADDR: begin
                  in_mode_d = fswd_in_t'(sif.cmd_data[2:1]);
                  sw_on_d   = sif.cmd_data[0];
               end
               `FSWD_CMD_OC_ADDR: lo_thr_d = sif.cmd_data[1:0];
               default: ;
            endcase
         end else if (ms_tick && wd_run_q) begin
            ms_d = 12'(ms_q + 12'h001);
         end
      end
      if (!wake_s) wd_run_d = 1'b0;               // Watchdog stopped while wake is low
      if (fs_disabled) begin
         wd_run_d = 1'b0;
         if (mode_q == FSWD_FAILSAFE && mode_d != FSWD_SLEEP) mode_d = FSWD_NORMAL;
      end else if (expire && !kick && mode_d != FSWD_SLEEP) begin // Sleep wins over a late expiry
         mode_d = FSWD_FAILSAFE; wd_run_d = 1'b0;
      end
      // Blanking counter restarts on each switch-on
      hb_d = (drive && hb_q != 16'(HBLANK_CYC)) ? 16'(hb_q + 16'h0001) : (drive ? hb_q : 16'h0000);
      if (rst_s) begin
         if (och_s) fault_d[0] = 1'b1;            // Severe short any time
         if (ocl_s && hb_q == 16'(HBLANK_CYC)) fault_d[1] = 1'b1; // Low trip after window
         if (thermal_fault) fault_d[2] = 1'b1;
         fault_d[3] = (mode_q == FSWD_FAILSAFE);
      end
   end

   // Load drive selection
   always_comb begin
      case (in_mode_q)
         FSWD_IN_DIRECT: drive = din_s;
         FSWD_IN_OFF:    drive = sw_on_q;
         FSWD_IN_AND:    drive = din_s && sw_on_q;
         default:        drive = din_s || sw_on_q;
      endcase
      if (mode_q == FSWD_SLEEP) drive = 1'b0;
      else if (mode_q == FSWD_FAILSAFE) drive = (fsi_s == `FSWD_FS_ON);
      if (fault_q[0] || fault_q[1] || fault_q[2]) drive = 1'b0;
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= FSWD_SLEEP; in_mode_q <= FSWD_IN_DIRECT; watchdog_period_sel_q <= 2'h0;
         lo_thr_q <= 2'h0; sw_on_q <= 1'b0; rst_prev_q <= 1'b0; wd_run_q <= 1'b0;
         ms_q <= 12'h000; div_q <= 32'h0000_0000; hb_q <= 16'h0000;
         fault_q <= `FSWD_FAULT_RESET; load_switch_output <= 1'b0;
      end else begin
         mode_q <= mode_d; in_mode_q <= in_mode_d; watchdog_period_sel_q <= watchdog_period_sel_d;
         lo_thr_q <= lo_thr_d; sw_on_q <= sw_on_d; rst_prev_q <= rst_s; wd_run_q <= wd_run_d;
         ms_q <= ms_d; div_q <= div_d; hb_q <= hb_d; fault_q <= fault_d;
         load_switch_output <= drive;
      end
   end

   assign sif.status_word    = fault_q;
   assign fault_flag_n_o     = 1'b0;
   assign fault_flag_n_oe    = any_fault;        // Pull low on fault
   assign low_trip_level_sel = lo_thr_q;

   a_sleep_output_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      (mode_q == FSWD_SLEEP) |=> !load_switch_output) else $error("load on in sleep");
   a_reset_clears_cfg: assert property (@(posedge core_clk) disable iff (!reset_n)
      !rst_s |=> (fault_q == 8'h00 && lo_thr_q == 2'h0)) else $error("cfg not cleared");
   a_wd_needs_wake: assert property (@(posedge core_clk) disable iff (!reset_n)
      !wake_s |=> !wd_run_q) else $error("watchdog runs without wake");
   a_wd_starts_rst: assert property (@(posedge core_clk) disable iff (!reset_n)
      (rst_s && !rst_prev_q && wake_s && !fs_disabled) |=> wd_run_q) else $error("timer not started");
   a_flag_follows_fault: assert property (@(posedge core_clk) disable iff (!reset_n)
      (rst_s && (och_s || thermal_fault)) |=> (fault_flag_n_oe && !fault_flag_n_o))
      else $error("fault flag mismatch");
   a_failsafe_on_expire: assert property (@(posedge core_clk) disable iff (!reset_n)
      (expire && !kick && !fs_disabled && (rst_s || wake_s)) |=> mode_q == FSWD_FAILSAFE)
      else $error("no failsafe");
   a_failsafe_drive: assert property (@(posedge core_clk) disable iff (!reset_n)
      (mode_q == FSWD_FAILSAFE && fault_q[2:0] == 3'h0) |=> load_switch_output == $past(fsi_s == `FSWD_FS_ON))
      else $error("failsafe drive wrong");
   a_select_gnd_off: assert property (@(posedge core_clk) disable iff (!reset_n)
      fs_disabled |=> !wd_run_q) else $error("watchdog on with select grounded");
   a_period_decode: assert property (@(posedge core_clk) disable iff (!reset_n)
      (watchdog_period_sel_q == 2'h2) |-> wd_ms(watchdog_period_sel_q) == 12'd2500)
      else $error("period decode");
   a_low_blank: assert property (@(posedge core_clk) disable iff (!reset_n)
      (rst_s && ocl_s && hb_q != 16'(HBLANK_CYC) && !fault_q[1]) |=> !fault_q[1])
      else $error("low trip inside blank");
   a_high_trip: assert property (@(posedge core_clk) disable iff (!reset_n)
      (rst_s && och_s) |=> fault_q[0]) else $error("severe short missed");
endmodule

// [tb/fswd_host.sv]
// Host controller model: control pins and an 8-bit serial master for the watchdog control.
// Assumes core_clk is the host's timebase; every pin moves on its falling edge.
`timescale 1ns/1ps
module fswd_host (
   // Clock
   input  wire logic       core_clk,
   // Serial answer from the device
   input  wire logic       serial_dout,
   input  wire logic       serial_dout_oe,
   // Pins towards the device
   output logic            wake_in,
   output logic            dev_reset_n,
   output logic            direct_in,
   output logic [1:0]      failsafe_select_input,
   output logic            chip_select_n,
   output logic            serial_clk,
   output logic            serial_din
);
   localparam int HALF  = 5;    // Serial clock phase, above the four cycles the shifter needs
   localparam int SETUP = 250;  // Reset release to first select, 5 us at 20 ns

   // Power-up state: reset held low until the supply is up, serial idle
   initial begin
      dev_reset_n           = 1'b0;
      wake_in               = 1'b0;
      direct_in             = 1'b0;
      failsafe_select_input = 2'h1;
      chip_select_n         = 1'b1;
      serial_clk            = 1'b0;
      serial_din            = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge core_clk);
   endtask

   // Level pins; a reset release is followed by the select setup wait
   task automatic pins(input logic w, input logic r, input logic d, input logic [1:0] f);
      logic rose;
      @(negedge core_clk);
      rose                  = r & ~dev_reset_n;
      wake_in               = w;
      dev_reset_n           = r;
      direct_in             = d;
      failsafe_select_input = f;
      if (rose) begin
         wait_cyc(SETUP);
      end
   endtask

   // One whole frame, MSB first; reply bits are read just before each rising clock
   task automatic xfer(input logic [7:0] cmd, output logic [7:0] rsp);
      @(negedge core_clk);
      chip_select_n = 1'b0;
      wait_cyc(HALF);
      for (int i = 7; i >= 0; i--) begin
         serial_din = cmd[i];
         wait_cyc(HALF);
         rsp[i]     = serial_dout_oe ? serial_dout : ~serial_dout; // A released line reads inverted
         serial_clk = 1'b1;
         wait_cyc(HALF);
         serial_clk = 1'b0;
      end
      wait_cyc(HALF);
      chip_select_n = 1'b1;
      serial_din    = 1'b0;
      wait_cyc(16); // Deselect time before any further frame
   endtask
endmodule

// [tb/fswd_top_tb.sv]
// Self-checking bench for the fail-safe watchdog control top.
// Assumes the host model drives all control and serial pins; sense inputs come from here.
`timescale 1ns/1ps
module fswd_top_tb;
   localparam int MSD   = 10;     // Shortened millisecond, in core cycles
   localparam int LIMIT = 90000;  // Ceiling on the whole run
   logic       core_clk, reset_n, wake_in, dev_reset_n, direct_in, chip_select_n, serial_clk;
   logic       serial_din, serial_dout, serial_dout_oe, oc_high_trip, oc_low_trip, thermal_fault;
   logic       load_switch_output, fault_flag_n_o, fault_flag_n_oe, fault_line;
   logic [1:0] failsafe_select_input, low_trip_level_sel;
   logic [7:0] rsp;
   int         n_fail, check_count, cyc;

   // Open-drain fault flag with its board pull-up
   assign fault_line = fault_flag_n_oe ? fault_flag_n_o : 1'b1;

   fswd_top #(.MS_DIV(MSD)) i_fswd_top (
      .core_clk           (core_clk),           .reset_n               (reset_n),
      .wake_in            (wake_in),            .dev_reset_n           (dev_reset_n),
      .direct_in          (direct_in),          .failsafe_select_input (failsafe_select_input),
      .chip_select_n      (chip_select_n),      .serial_clk            (serial_clk),
      .serial_din         (serial_din),         .serial_dout           (serial_dout),
      .serial_dout_oe     (serial_dout_oe),     .oc_high_trip          (oc_high_trip),
      .oc_low_trip        (oc_low_trip),        .thermal_fault         (thermal_fault),
      .load_switch_output (load_switch_output), .fault_flag_n_o        (fault_flag_n_o),
      .fault_flag_n_oe    (fault_flag_n_oe),    .low_trip_level_sel    (low_trip_level_sel));
   fswd_host i_fswd_host (
      .core_clk           (core_clk),           .serial_dout           (serial_dout),
      .serial_dout_oe     (serial_dout_oe),     .wake_in               (wake_in),
      .dev_reset_n        (dev_reset_n),        .direct_in             (direct_in),
      .failsafe_select_input (failsafe_select_input),
      .chip_select_n      (chip_select_n),      .serial_clk            (serial_clk),
      .serial_din         (serial_din));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_bit(input logic got, input logic exp);
      check_byte({7'h00, got}, {7'h00, exp});
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Hang guard: a run past the ceiling counts as a failure
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         n_fail++;
         print_verdict();
      end
   end

   task automatic t_sleep_reset;
      i_fswd_host.wait_cyc(8);
      check_bit(load_switch_output, 1'b0);
      check_bit(fault_line, 1'b1);
      check_bit(serial_dout_oe, 1'b0);
      check_byte({6'h00, low_trip_level_sel}, 8'h00);
   endtask

   // Every input mode against all pin and serial-bit states
   task automatic t_drive;
      logic exp;
      for (int m = 0; m < 4; m++) begin
         for (int k = 0; k < 4; k++) begin
            i_fswd_host.pins(1'b1, 1'b1, 1'b0, 2'h2);
            i_fswd_host.xfer({4'h2, 1'b0, m[1:0], k[0]}, rsp);
            i_fswd_host.pins(1'b1, 1'b1, k[1], 2'h2);
            i_fswd_host.wait_cyc(8);
            exp = (m == 0) ? k[1] : (m == 1) ? k[0] : (m == 2) ? (k[1] & k[0]) : (k[1] | k[0]);
            check_bit(load_switch_output, exp);
         end
      end
   endtask

   // Threshold codes, then sleep must wipe them and drop the load
   task automatic t_lowtrip;
      for (int v = 0; v < 4; v++) begin
         i_fswd_host.xfer({6'h0c, v[1:0]}, rsp);
         i_fswd_host.wait_cyc(4);
         check_byte({6'h00, low_trip_level_sel}, {6'h00, v[1:0]});
      end
      i_fswd_host.pins(1'b0, 1'b0, 1'b1, 2'h2);
      i_fswd_host.wait_cyc(8);
      check_bit(load_switch_output, 1'b0);
      check_byte({6'h00, low_trip_level_sel}, 8'h00);
   endtask

   // Faults held well past the high blanking window, read back, then cleared by reset
   task automatic t_fault;
      i_fswd_host.pins(1'b1, 1'b1, 1'b1, 2'h2);
      // Low trip inside the blanking count is ignored; past it the fault latches and drops the load
      oc_low_trip   = 1'b1;
      i_fswd_host.wait_cyc(100);
      check_bit(fault_line, 1'b1);
      i_fswd_host.wait_cyc(300);
      check_bit(fault_line, 1'b0);
      check_bit(load_switch_output, 1'b0);
      oc_low_trip   = 1'b0;
      oc_high_trip  = 1'b1;
      thermal_fault = 1'b1;
      i_fswd_host.wait_cyc(700);
      oc_high_trip  = 1'b0;
      thermal_fault = 1'b0;
      i_fswd_host.wait_cyc(8);
      check_bit(fault_line, 1'b0);
      i_fswd_host.xfer(8'h00, rsp);
      check_byte(rsp, 8'h07);
      check_bit(serial_dout_oe, 1'b0);
      i_fswd_host.pins(1'b1, 1'b0, 1'b0, 2'h2);
      i_fswd_host.wait_cyc(8);
      check_bit(fault_line, 1'b1);
   endtask

   // One period code; odd codes pick the on select, even codes the off select
   task automatic t_timeout(input logic [1:0] code);
      int   n;
      logic on;
      on = code[0];
      n  = (code == 2'h0) ? 620 : (code == 2'h1) ? 310 : (code == 2'h2) ? 2500 : 1250;
      i_fswd_host.pins(1'b1, 1'b1, ~on, {1'b0, on});
      i_fswd_host.xfer({6'h04, code}, rsp);
      i_fswd_host.wait_cyc(n * MSD - 60);
      check_bit(load_switch_output, ~on);
      i_fswd_host.wait_cyc(100);
      check_bit(load_switch_output, on);
      if (code[1]) begin
         // Grounding the select also leaves fail-safe, handing the load back to the pin
         i_fswd_host.pins(1'b1, 1'b1, ~on, 2'h2);
         i_fswd_host.wait_cyc(8);
         check_bit(load_switch_output, ~on);
      end
      i_fswd_host.pins(1'b0, 1'b0, 1'b0, {1'b0, on});
      i_fswd_host.wait_cyc(8);
      check_bit(load_switch_output, 1'b0);
   endtask

   // No expiry with wake low, nor with the select grounded
   task automatic t_quiet;
      for (int i = 0; i < 2; i++) begin
         // Pin level differs from what a fail-safe entry would drive, so an expiry shows
         i_fswd_host.pins(i[0], 1'b1, i[0], i[0] ? 2'h2 : 2'h1);
         i_fswd_host.wait_cyc(6400);
         check_bit(load_switch_output, i[0]);
         i_fswd_host.pins(1'b0, 1'b0, 1'b0, 2'h1);
      end
   endtask

   initial begin
      reset_n       = 1'b0;
      oc_high_trip  = 1'b0;
      oc_low_trip   = 1'b0;
      thermal_fault = 1'b0;
      repeat (4) @(negedge core_clk);
      reset_n = 1'b1;
      t_sleep_reset();
      t_drive();
      t_lowtrip();
      t_fault();
      for (int c = 0; c < 4; c++) begin
         t_timeout(c[1:0]);
      end
      t_quiet();
      print_verdict();
   end
endmodule
